// file: cfp_pkg.sv
// Shared constants and types for the configuration port block.
// Assumes a single 100 MHz system clock; no software registers.
package cfp_pkg;

	// Mode pin encodings (integrator-defined)
	localparam logic [2:0] MODE_MASTER_SERIAL = 3'h0;
	localparam logic [2:0] MODE_SLAVE_SERIAL  = 3'h7;
	localparam logic [2:0] MODE_BYTE_PARALLEL = 3'h6;

	// Memory clear time and divider
	localparam int CLEAR_NS      = 1000;
	localparam int CLK_NS        = 10;
	localparam int CLEAR_CYCLES  = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
	localparam int CFG_CLOCK_HALF = 4;
	localparam int HEADER_BITS   = 64;
	localparam int STARTUP_CYC   = 8;
	localparam int BUSY_CYC      = 2;
	localparam logic [31:0] LOAD_BITS_DEFAULT = 32'h0000_0400;

	typedef enum logic [1:0] {
		CFP_MS,
		CFP_SS,
		CFP_BP
	} cfp_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CLEAR,
		ST_LOAD,
		ST_STARTUP,
		ST_USER
	} cfp_state_e;

endpackage : cfp_pkg

// file: cfp_sync_if.sv
// Bundle of synchronised pin levels passed from the sampler to the core.
// Assumes both ends share CLK.
`timescale 1ns/100ps
`default_nettype none
interface cfp_sync_if;
	logic       prog_n;
	logic [2:0] mode;
	logic       cfg_clock;
	logic       din;
	logic [7:0] data;
	logic       write_n;
	logic       cs_n;
	modport src (output prog_n, mode, cfg_clock, din, data, write_n, cs_n);
	modport dst (input  prog_n, mode, cfg_clock, din, data, write_n, cs_n);
endinterface : cfp_sync_if
`default_nettype wire

// file: cfp_sync.sv
// Two-stage synchroniser for every pin input of the configuration port except RETAIN_PORT and DONE_OPEN_DRAIN.
// Assumes pins are asynchronous to CLK.
`timescale 1ns/100ps
`default_nettype none
module cfp_sync
	import cfp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic [15:0] pins,
	cfp_sync_if.src         sy
);
	logic [15:0] stage1;
	logic [15:0] stage2;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1 <= 16'hFFFF;
			stage2 <= 16'hFFFF;
		end else begin
			stage1 <= pins;
			stage2 <= stage1;
		end
	end

	assign sy.prog_n  = stage2[0];
	assign sy.mode    = stage2[3:1];
	assign sy.cfg_clock = stage2[4];
	assign sy.din     = stage2[5];
	assign sy.data    = stage2[13:6];
	assign sy.write_n = stage2[14];
	assign sy.cs_n    = stage2[15];
endmodule : cfp_sync
`default_nettype wire

// file: cfp_config_port.sv
// Configuration port core: restart, clear, load, start-up, user release.
// Assumes CLK at 100 MHz, pins asynchronous, board resolves open drain.
//
// How it works
// - Clock pin input except master serial output
// - After configuration clock pin level ignored
// - Restart pin low starts new configuration
// - Done pin shows load complete, start-up
// - Clear pin low during memory clear
// - Busy output paces parallel byte loading
// - Parallel pins freed unless port retained
// - Serial modes pass header on chain output
// - Eight data pins carry parallel bytes
// - Serial modes load one data input
// - Three mode pins choose configuration mode
`timescale 1ns/100ps
`default_nettype none
module cfp_config_port
	import cfp_pkg::*;
#(
	parameter logic [31:0] LOAD_BITS = LOAD_BITS_DEFAULT
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       NRST,
	// Control pins
	input  wire logic       PROG_N,
	input  wire logic [2:0] MODE_SEL,
	input  wire logic       RETAIN_PORT,
	input  wire logic       DONE_OPEN_DRAIN,
	// Configuration clock pin
	input  wire logic       CFG_CLOCK_I,
	output logic            CFG_CLOCK_O,
	output logic            CFG_CLOCK_OE,
	// Status pins
	output logic            DONE_O,
	output logic            DONE_OE,
	output logic            CLEAR_N_O,
	output logic            CLEAR_N_OE,
	// Data pins
	input  wire logic [7:0] DATA_I,
	input  wire logic       WRITE_N,
	input  wire logic       CS_N,
	output logic            BUSY_DOUT_O,
	output logic            BUSY_DOUT_OE,
	// Loaded stream and state
	output logic [7:0]      LOAD_DATA,
	output logic            LOAD_VALID,
	output logic            USER_MODE
);
	// ************************************************
	// Pin sampling
	// ************************************************
	cfp_sync_if sy();
	cfp_sync u_sync (
		.clk  (CLK),
		.nrst (NRST),
		.pins ({CS_N, WRITE_N, DATA_I, DATA_I[0], CFG_CLOCK_I,
			MODE_SEL, PROG_N}),
		.sy   (sy)
	);

	cfp_state_e  state;
	cfp_mode_e   mode;
	logic [31:0] count;
	logic [2:0]  div;
	logic        cfg_clock_out;
	logic        cfg_clock_prev;
	logic        cfg_clock_rise;
	logic        wr_prev;
	logic [1:0]  busy_cnt;
	logic [7:0]  shift;
	logic [2:0]  bit_idx;
	logic        dout;

	function automatic cfp_mode_e decode_mode(input logic [2:0] m);
		unique case (m)
			MODE_MASTER_SERIAL: decode_mode = CFP_MS;
			MODE_BYTE_PARALLEL: decode_mode = CFP_BP;
			default:            decode_mode = CFP_SS;
		endcase
	endfunction : decode_mode

	// ************************************************
	// Configuration clock
	// ************************************************
	// Master serial drives its own divided clock
	always_ff @(posedge CLK) begin
		if (!NRST || state != ST_LOAD || mode != CFP_MS) begin
			div           <= 3'h0;
			cfg_clock_out <= 1'b0;
		end else if (div == 3'(CFG_CLOCK_HALF - 1)) begin
			div           <= 3'h0;
			cfg_clock_out <= ~cfg_clock_out;
		end else begin
			div <= div + 3'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST)
			cfg_clock_prev <= 1'b0;
		else
			cfg_clock_prev <= (mode == CFP_MS) ? cfg_clock_out : sy.cfg_clock;
	end
	// Only used while loading; level ignored after configuration
	assign cfg_clock_rise = (state == ST_LOAD) && !cfg_clock_prev &&
		((mode == CFP_MS) ? (cfg_clock_out && div == 3'h0) :
		sy.cfg_clock);

	assign CFG_CLOCK_O  = cfg_clock_out;
	assign CFG_CLOCK_OE = (state == ST_LOAD) && (mode == CFP_MS);

	// ************************************************
	// Sequence
	// ************************************************
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state <= ST_IDLE;
			mode  <= CFP_SS;
			count <= 32'h0;
		end else if (!sy.prog_n) begin
			state <= ST_CLEAR;
			mode  <= decode_mode(sy.mode);
			count <= 32'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					state <= ST_CLEAR;
					mode  <= decode_mode(sy.mode);
					count <= 32'h0;
				end
				ST_CLEAR: begin
					if (count == 32'(CLEAR_CYCLES - 1)) begin
						state <= ST_LOAD;
						count <= 32'h0;
					end else
						count <= count + 32'h1;
				end
				ST_LOAD: begin
					if (count >= LOAD_BITS) begin
						state <= ST_STARTUP;
						count <= 32'h0;
					end else if (mode == CFP_BP) begin
						if (!sy.cs_n && !sy.write_n && wr_prev &&
							busy_cnt == 2'h0)
							count <= count + 32'h8;
					end else if (cfg_clock_rise)
						count <= count + 32'h1;
				end
				ST_STARTUP: begin
					if (count == 32'(STARTUP_CYC - 1))
						state <= ST_USER;
					else
						count <= count + 32'h1;
				end
				ST_USER: state <= ST_USER;
			endcase
		end
	end

	// ************************************************
	// Byte port pacing
	// ************************************************
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			wr_prev  <= 1'b1;
			busy_cnt <= 2'h0;
		end else begin
			wr_prev <= sy.write_n;
			if (state == ST_LOAD && mode == CFP_BP && !sy.cs_n &&
				!sy.write_n && wr_prev && busy_cnt == 2'h0)
				busy_cnt <= 2'(BUSY_CYC);
			else if (busy_cnt != 2'h0)
				busy_cnt <= busy_cnt - 2'h1;
		end
	end

	// ************************************************
	// Data capture and chain output
	// ************************************************
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			shift      <= 8'h00;
			bit_idx    <= 3'h0;
			LOAD_DATA  <= 8'h00;
			LOAD_VALID <= 1'b0;
			dout       <= 1'b0;
		end else begin
			LOAD_VALID <= 1'b0;
			if (state == ST_LOAD && mode == CFP_BP && !sy.cs_n &&
				!sy.write_n && wr_prev && busy_cnt == 2'h0) begin
				LOAD_DATA  <= sy.data;
				LOAD_VALID <= 1'b1;
			end else if (state == ST_LOAD && mode != CFP_BP &&
				cfg_clock_rise) begin
				shift   <= {shift[6:0], sy.din};
				bit_idx <= bit_idx + 3'h1;
				if (count < 32'(HEADER_BITS))
					dout <= sy.din;
				if (bit_idx == 3'h7) begin
					LOAD_DATA  <= {shift[6:0], sy.din};
					LOAD_VALID <= 1'b1;
				end
			end else if (state != ST_LOAD) begin
				// Restart mid-byte must not skew the next load
				bit_idx <= 3'h0;
			end
		end
	end

	// ************************************************
	// Pin drivers
	// ************************************************
	assign USER_MODE  = (state == ST_USER);
	// Done driven high only when push-pull; open drain floats high
	assign DONE_O     = (state == ST_STARTUP || state == ST_USER);
	assign DONE_OE    = DONE_OPEN_DRAIN ? !DONE_O : 1'b1;
	assign CLEAR_N_O  = 1'b0;
	assign CLEAR_N_OE = (state == ST_CLEAR || state == ST_IDLE);
	assign BUSY_DOUT_O = (mode == CFP_BP) ? (busy_cnt != 2'h0) : dout;
	// Released to user logic after configuration unless byte parallel with RETAIN_PORT
	assign BUSY_DOUT_OE = (state == ST_LOAD) ||
		(state == ST_STARTUP) ||
		(state == ST_USER && mode == CFP_BP && RETAIN_PORT);
endmodule : cfp_config_port
`default_nettype wire

// file: cfp_assertions.sv
// Checker for the configuration port pins.
// Assumes it is bound to cfp_config_port and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module cfp_assertions (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Pins watched
	input wire logic PROG_N,
	input wire logic RETAIN_PORT,
	input wire logic DONE_OPEN_DRAIN,
	input wire logic CFG_CLOCK_OE,
	input wire logic DONE_O,
	input wire logic DONE_OE,
	input wire logic CLEAR_N_O,
	input wire logic CLEAR_N_OE,
	input wire logic BUSY_DOUT_OE,
	input wire logic LOAD_VALID,
	input wire logic USER_MODE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	// ********************
	// Restart and status
	// ********************
	// Sync stages plus state register
	sequence s_restart;
		!PROG_N [*3];
	endsequence
	a_restart_clear: assert property (s_restart |-> ##[0:5] CLEAR_N_OE)
		else $error("restart did not clear");
	a_clear_low: assert property (CLEAR_N_OE |-> !CLEAR_N_O)
		else $error("clear pin not low");
	a_clear_idle: assert property (CLEAR_N_OE |-> !USER_MODE && !DONE_O)
		else $error("clear during done");
	a_done_od: assert property (DONE_OPEN_DRAIN && DONE_OE |-> !DONE_O)
		else $error("open drain done drove high");
	a_user_done: assert property (USER_MODE |-> DONE_O)
		else $error("user without done");
	a_user_clock: assert property (
		USER_MODE |-> !CFG_CLOCK_OE && !LOAD_VALID)
		else $error("clock used after config");
	a_busy_free: assert property (
		USER_MODE && !RETAIN_PORT |-> !BUSY_DOUT_OE)
		else $error("busy pin not freed");
	a_valid_pulse: assert property (LOAD_VALID |=> !LOAD_VALID)
		else $error("valid longer than a cycle");
	a_clock_load: assert property (
		CFG_CLOCK_OE |-> !CLEAR_N_OE && !DONE_O)
		else $error("clock driven outside load");
endmodule : cfp_assertions
`default_nettype wire

// file: cfp_partner.sv
// Model of the external configuration controller.
// Assumes calls start just after a falling CLK edge.
`timescale 1ns/100ps
`default_nettype none
module cfp_partner (
	// System clock and device busy
	input  wire logic       clk,
	input  wire logic       busy,
	// Pins toward the device
	output logic            cfg_clock,
	output logic [7:0]      data,
	output logic            write_n,
	output logic            cs_n
);
	initial begin
		cfg_clock = 1'b0;
		data = 8'h00;
		write_n = 1'b1;
		cs_n = 1'b1;
	end
	// Clock stands low between frames; MSB first
	task automatic send_serial(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			data[0] = v[i];
			#80 cfg_clock = 1'b1;
			// Release in the high phase, clear of the next frame's first bit
			#40 if (i == 0) data = ~data;
			#40 cfg_clock = 1'b0;
		end
	endtask : send_serial
	// Released bus shows the inverse so stale data never matches
	task automatic write_byte(input logic [7:0] v);
		int n = 0;
		// Let an edge pass after the previous release
		@(negedge clk);
		while (busy === 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		data = v;
		cs_n = 1'b0;
		write_n = 1'b0;
		repeat (4) @(negedge clk);
		write_n = 1'b1;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		data = ~v;
	endtask : write_byte
endmodule : cfp_partner
`default_nettype wire

// file: cfp_config_port_tb.sv
// Testbench for the configuration port core.
// Assumes LOAD_BITS of 64, so eight bytes finish a load.
`timescale 1ns/100ps
`default_nettype none
module cfp_config_port_tb;
	logic clk = 1'b0;
	logic nrst, prog_n, retain, done_od;
	logic cfg_clock_i, cfg_clock_o, cfg_clock_oe;
	logic pin_seen[$];
	logic done_o, done_oe, clr_o, clr_oe, write_n, cs_n, busy_o, busy_oe;
	logic valid, user;
	logic [2:0] mode;
	logic [7:0] data_i, ld;
	logic [7:0] got[$];
	int num_errors = 0;
	int total_checks = 0;

	cfp_config_port #(.LOAD_BITS(32'h0000_0040)) u_dut (.CLK(clk),
		.NRST(nrst), .PROG_N(prog_n), .MODE_SEL(mode), .RETAIN_PORT(retain),
		.DONE_OPEN_DRAIN(done_od), .CFG_CLOCK_I(cfg_clock_i),
		.CFG_CLOCK_O(cfg_clock_o),
		.CFG_CLOCK_OE(cfg_clock_oe), .DONE_O(done_o), .DONE_OE(done_oe),
		.CLEAR_N_O(clr_o), .CLEAR_N_OE(clr_oe), .DATA_I(data_i),
		.WRITE_N(write_n), .CS_N(cs_n), .BUSY_DOUT_O(busy_o),
		.BUSY_DOUT_OE(busy_oe), .LOAD_DATA(ld), .LOAD_VALID(valid),
		.USER_MODE(user));
	cfp_partner u_partner (.clk(clk), .busy(busy_o), .cfg_clock(cfg_clock_i),
		.data(data_i), .write_n(write_n), .cs_n(cs_n));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sampled mid-cycle, clear of the edge that launches the pulse
	always @(negedge clk) begin
		if (valid === 1'b1) begin
			got.push_back(ld);
			pin_seen.push_back(busy_o);
		end
	end
	initial begin
		#100000 num_errors++;
		end_sim();
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic restart(input logic [2:0] m);
		mode = m;
		prog_n = 1'b0;
		repeat (4) @(negedge clk);
		chk("clear_oe", 1, clr_oe);
		chk("clear_o", 0, clr_o);
		prog_n = 1'b1;
		got.delete();
		pin_seen.delete();
		repeat (110) @(negedge clk);
		chk("clear_end", 0, clr_oe);
	endtask : restart
	task automatic finish_load();
		for (int i = 0; i < 40 && done_o !== 1'b1; i++) @(negedge clk);
		chk("done", 1, done_o);
		chk("startup", 0, user);
		repeat (10) @(negedge clk);
		chk("user", 1, user);
		chk("busy_oe", 0, busy_oe);
	endtask : finish_load
	task automatic t_byte();
		restart(3'h6);
		chk("cfg_clock_oe", 0, cfg_clock_oe);
		for (int i = 0; i < 8; i++)
			u_partner.write_byte(8'hA0 + 8'(i));
		finish_load();
		chk("done_oe", 1, done_oe);
		chk("count", 8, 8'(got.size()));
		for (int i = 0; i < 8; i++)
			chk("byte", 8'hA0 + 8'(i), got[i]);
		for (int i = 0; i < 8; i++)
			chk("busy", 1, 8'(pin_seen[i]));
		// Retained port keeps the busy pin driven
		retain = 1'b1;
		@(negedge clk);
		chk("retain_oe", 1, busy_oe);
		retain = 1'b0;
	endtask : t_byte
	task automatic t_serial();
		done_od = 1'b1;
		restart(3'h7);
		chk("dout_oe", 1, busy_oe);
		for (int i = 0; i < 8; i++)
			u_partner.send_serial(8'h5C ^ 8'(i));
		finish_load();
		chk("done_oe", 0, done_oe);
		u_partner.send_serial(8'hFF);
		chk("count", 8, 8'(got.size()));
		for (int i = 0; i < 8; i++)
			chk("bit", 8'h5C ^ 8'(i), got[i]);
		// Chain output repeats the last header bit of each byte as it is taken
		for (int i = 0; i < 8; i++)
			chk("chain", (8'h5C ^ 8'(i)) & 8'h01, 8'(pin_seen[i]));
	endtask : t_serial
	task automatic t_master();
		int n = 0;
		logic p;
		restart(3'h0);
		chk("cfg_clock_oe", 1, cfg_clock_oe);
		mode = 3'h6;
		p = cfg_clock_o;
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			if (cfg_clock_o !== p) n++;
			p = cfg_clock_o;
		end
		chk("toggles", 4, 8'(n));
		chk("mode_held", 1, cfg_clock_oe);
	endtask : t_master
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	initial begin
		{nrst, retain, done_od} = 3'b000;
		prog_n = 1'b1;
		mode = 3'h6;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		t_byte();
		t_serial();
		t_master();
		end_sim();
	end
endmodule : cfp_config_port_tb

bind cfp_config_port cfp_assertions u_chk (.CLK(CLK), .NRST(NRST),
	.PROG_N(PROG_N), .RETAIN_PORT(RETAIN_PORT),
	.DONE_OPEN_DRAIN(DONE_OPEN_DRAIN), .CFG_CLOCK_OE(CFG_CLOCK_OE),
	.DONE_O(DONE_O), .DONE_OE(DONE_OE), .CLEAR_N_O(CLEAR_N_O),
	.CLEAR_N_OE(CLEAR_N_OE), .BUSY_DOUT_OE(BUSY_DOUT_OE),
	.LOAD_VALID(LOAD_VALID), .USER_MODE(USER_MODE));
`default_nettype wire
